// File: verilog/dzc_top.sv
// Impedance calibration command handling inside the memory device.
`timescale 1ns/100ps
// Behaviour
// - First long calibration after reset finishes, values loaded, within the init window.
// - Later long calibrations finish, values loaded, within the operating window.
// - Short calibration finishes within its window; correction applied within 64 cycles.
// - Long command starts the engine; results load into I/O drivers and termination.
// - After self refresh exit, calibration only happens on an explicit command.
// - Device switches off the calibration pin current once calibration completes.
// - Overlapped entry then exit: termination response uncertain from entry start to exit end.
// - Overlapped exit then entry: termination response uncertain from exit start to entry end.
// - Transition period begins WL minus 1 cycles before clock enable changes; o_odt_uncertain only rises once the change is sampled.
module dzc_top
  import dzc_pkg::*;
#(
  parameter int ZQINIT_NCK = DZC_ZQINIT_NCK,
  parameter int ZQOPER_NCK = DZC_ZQOPER_NCK,
  parameter int ZQCS_NCK = DZC_ZQCS_NCK
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ck,
  input wire dzc_pkg::dzc_link_t i_link,
  input wire logic i_self_refresh,
  input wire logic [dzc_pkg::DZC_WL_W-1:0] i_wl,
  input wire logic [dzc_pkg::DZC_CODE_W-1:0] i_target_ron,
  input wire logic [dzc_pkg::DZC_CODE_W-1:0] i_target_rtt,
  output logic o_busy,
  output logic o_zq_current_en,
  output dzc_pkg::dzc_codes_t o_codes,
  output logic o_odt_uncertain,
  output logic o_first_done,
  output logic o_violation
);
  import dzc_pkg::*;

  typedef enum logic [1:0] {
    DZC_IDLE = 2'b00,
    DZC_LONG = 2'b01,
    DZC_SHORT = 2'b10
  } dzc_state_t;

  // ==========================================================================
  // Synchronise the link clock and command pins.
  // ==========================================================================
  logic [4:0] raw_pins, sync_pins;
  dzc_link_t link_s;
  logic ck_s, ck_q, ck_d, ck_rise;

  assign raw_pins = {i_ck, i_link};

  dzc_sync #(.W(5)) u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async(raw_pins),
    .o_sync(sync_pins)
  );

  assign ck_s = sync_pins[4];
  assign link_s = dzc_link_t'(sync_pins[3:0]);
  assign ck_d = ck_s;
  assign ck_rise = ck_s & ~ck_q;

  // ==========================================================================
  // Calibration engine state.
  // ==========================================================================
  dzc_state_t st_q, st_d;
  logic [DZC_CNT_W-1:0] cnt_q, cnt_d;
  logic first_q, first_d;
  dzc_codes_t codes_q, codes_d;
  logic viol_q, viol_d;

  function automatic logic [DZC_CODE_W-1:0] dzc_step(
    input logic [DZC_CODE_W-1:0] cur,
    input logic [DZC_CODE_W-1:0] tgt
  );
    if (cur < tgt) begin
      return cur + 8'h01;
    end else if (cur > tgt) begin
      return cur - 8'h01;
    end
    return cur;
  endfunction : dzc_step

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    first_d = first_q;
    codes_d = codes_q;
    viol_d = viol_q;
    if (ck_rise) begin
      unique case (st_q)
        DZC_IDLE: begin
          // Self refresh exit alone never starts the engine.
          if (link_s.cmd == DZC_CMD_LONG) begin
            st_d = DZC_LONG;
            cnt_d = first_q ? DZC_CNT_W'(ZQOPER_NCK - 1)
                            : DZC_CNT_W'(ZQINIT_NCK - 1);
          end else if (link_s.cmd == DZC_CMD_SHORT) begin
            st_d = DZC_SHORT;
            cnt_d = DZC_CNT_W'(ZQCS_NCK - 1);
          end
        end
        DZC_LONG, DZC_SHORT: begin
          if (link_s.cmd != DZC_CMD_NONE || !link_s.cke || link_s.odt) begin
            viol_d = 1'b1;
          end
          if (cnt_q == '0) begin
            st_d = DZC_IDLE;
            if (st_q == DZC_LONG) begin
              codes_d.ron = i_target_ron;
              codes_d.rtt = i_target_rtt;
              first_d = 1'b1;
            end else begin
              codes_d.ron = dzc_step(codes_q.ron, i_target_ron);
              codes_d.rtt = dzc_step(codes_q.rtt, i_target_rtt);
            end
          end else begin
            cnt_d = cnt_q - DZC_CNT_W'(1);
          end
        end
        default: st_d = DZC_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ck_q <= 1'b0;
      st_q <= DZC_IDLE;
      cnt_q <= '0;
      first_q <= 1'b0;
      codes_q <= '{ron: DZC_CODE_RESET, rtt: DZC_CODE_RESET};
      viol_q <= 1'b0;
    end else begin
      ck_q <= ck_d;
      st_q <= st_d;
      cnt_q <= cnt_d;
      first_q <= first_d;
      codes_q <= codes_d;
      viol_q <= viol_d;
    end
  end

  // ==========================================================================
  // Power-down transition windows for termination response.
  // ==========================================================================
  logic cke_prev_q, cke_prev_d;
  logic [DZC_WL_W-1:0] tail_q, tail_d;
  logic unc_q, unc_d;
  logic [DZC_WL_W-1:0] lead;

  assign lead = i_wl - DZC_WL_W'(1);

  always_comb begin
    cke_prev_d = cke_prev_q;
    tail_d = tail_q;
    unc_d = unc_q;
    if (ck_rise) begin
      cke_prev_d = link_s.cke;
      if (link_s.cke != cke_prev_q) begin
        // The window opened WL-1 cycles back, so it is held open from here.
        unc_d = 1'b1;
        // Extend to cover an overlapping opposite transition.
        tail_d = lead;
      end else if (tail_q != '0) begin
        tail_d = tail_q - DZC_WL_W'(1);
      end else begin
        unc_d = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      // Clock enable idles high, so no false transition follows reset.
      cke_prev_q <= 1'b1;
      tail_q <= '0;
      unc_q <= 1'b0;
    end else begin
      cke_prev_q <= cke_prev_d;
      tail_q <= tail_d;
      unc_q <= unc_d;
    end
  end

  assign o_busy = (st_q != DZC_IDLE);
  assign o_zq_current_en = (st_q != DZC_IDLE);
  assign o_codes = codes_q;
  assign o_odt_uncertain = unc_q;
  assign o_first_done = first_q;
  assign o_violation = viol_q;

endmodule : dzc_top

// File: verilog/dzc_pkg.sv
// Package of constants and types for the DRAM impedance calibration block.
package dzc_pkg;

  // ==========================================================================
  // Command encodings.
  // ==========================================================================
  typedef enum logic [1:0] {
    DZC_CMD_NONE  = 2'b00,
    DZC_CMD_LONG  = 2'b01,
    DZC_CMD_SHORT = 2'b10,
    DZC_CMD_OTHER = 2'b11
  } dzc_cmd_t;

  // ==========================================================================
  // Timing constants in link clock cycles, with widths and reset values.
  // ==========================================================================
  localparam int DZC_ZQINIT_NCK = 512;
  localparam int DZC_ZQOPER_NCK = 256;
  localparam int DZC_ZQCS_NCK = 64;
  localparam int DZC_SHORT_CORR_NCK = 64;
  localparam int DZC_CNT_W = 16;
  localparam int DZC_CODE_W = 8;
  localparam int DZC_WL_W = 5;
  localparam logic [DZC_CODE_W-1:0] DZC_CODE_RESET = 8'h80;
  localparam logic [DZC_WL_W-1:0] DZC_WL_DEFAULT = 5'h05;

  // ==========================================================================
  // Command sampled on a link clock edge.
  // ==========================================================================
  typedef struct packed {
    logic cke;
    logic odt;
    dzc_cmd_t cmd;
  } dzc_link_t;

  // ==========================================================================
  // Calibrated impedance codes loaded into the I/O.
  // ==========================================================================
  typedef struct packed {
    logic [DZC_CODE_W-1:0] ron;
    logic [DZC_CODE_W-1:0] rtt;
  } dzc_codes_t;

endpackage : dzc_pkg

// File: verilog/dzc_sync.sv
// Three-stage synchroniser with agreement filter for a pin group.
`timescale 1ns/100ps
module dzc_sync #(
  parameter int W = 4
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] s1_q, s1_d, s2_q, s2_d, s3_q, s3_d, out_q, out_d;

  always_comb begin
    s1_d = i_async;
    s2_d = s1_q;
    s3_d = s2_q;
    out_d = (s2_q == s3_q) ? s3_q : out_q;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      out_q <= out_d;
    end
  end

  assign o_sync = out_q;
endmodule : dzc_sync

// File: verification/dzc_checker.sv
// Checker of calibration window behaviour at the block ports.
`timescale 1ns/100ps
module dzc_checker
  import dzc_pkg::*;
#(
  parameter int ZQINIT_NCK = DZC_ZQINIT_NCK
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ck,
  input wire dzc_pkg::dzc_link_t i_link,
  input wire logic [dzc_pkg::DZC_CODE_W-1:0] i_target_ron,
  input wire logic [dzc_pkg::DZC_CODE_W-1:0] i_target_rtt,
  input wire logic o_busy,
  input wire logic o_zq_current_en,
  input wire dzc_pkg::dzc_codes_t o_codes,
  input wire logic o_odt_uncertain,
  input wire logic o_first_done,
  input wire logic o_violation
);
  logic ck_q;
  logic [15:0] ne_q;
  logic [15:0] ne_d;
  always_comb begin
    ne_d = o_busy ? ne_q + 16'(i_ck & !ck_q) : 16'h0000;
  end
  always_ff @(posedge i_clk) begin
    ck_q <= i_ck;
    ne_q <= i_rst ? 16'h0000 : ne_d;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence done_s;
    $fell(o_busy);
  endsequence
  sequence cke_s;
    $changed(i_link.cke);
  endsequence
  cur_path_a: assert property (o_zq_current_en == o_busy) else $error("path");
  reset_quiet_a:
    assert property (disable iff (1'b0) i_rst |=> !o_busy && !o_first_done) else $error("rst");
  first_end_a: assert property ($rose(o_first_done) |-> done_s) else $error("end");
  first_load_a:
    assert property ($rose(o_first_done) |-> o_codes == {i_target_ron, i_target_rtt})
    else $error("load");
  codes_idle_a:
    assert property (!o_busy && !$past(o_busy) |-> $stable(o_codes)) else $error("idle");
  busy_bound_a:
    assert property (o_busy |-> ne_q <= ZQINIT_NCK + 2) else $error("long window");
  viol_hold_a: assert property (o_violation |=> o_violation) else $error("viol");
  first_hold_a: assert property (o_first_done |=> o_first_done) else $error("first");
  uncert_a:
    assert property (cke_s |-> ##[1:12] o_odt_uncertain) else $error("uncertain");
endmodule : dzc_checker
bind dzc_top dzc_checker #(.ZQINIT_NCK(ZQINIT_NCK)) dzc_checker_inst (.i_clk(i_clk),
  .i_rst(i_rst), .i_ck(i_ck), .i_link(i_link), .i_target_ron(i_target_ron),
  .i_target_rtt(i_target_rtt), .o_busy(o_busy), .o_zq_current_en(o_zq_current_en),
  .o_codes(o_codes), .o_odt_uncertain(o_odt_uncertain), .o_first_done(o_first_done),
  .o_violation(o_violation));

// File: verification/dzc_ctrl_model.sv
// Memory controller model driving the link clock and command pins.
`timescale 1ns/100ps
module dzc_ctrl_model
  import dzc_pkg::*;
(
  input wire logic i_run,
  input wire dzc_pkg::dzc_cmd_t i_cmd,
  input wire logic i_cke,
  input wire logic i_odt,
  output logic o_ck,
  output dzc_pkg::dzc_link_t o_link
);
  initial begin
    o_ck = 1'b0;
    o_link = '{1'b1, 1'b0, DZC_CMD_NONE};
    #13;
    forever #400 if (i_run || o_ck) o_ck = !o_ck;
  end
  // Pins change on the falling link edge and hold over the rising one.
  always @(negedge o_ck) begin
    o_link.cmd <= i_cmd;
    o_link.cke <= i_cke;
    o_link.odt <= i_odt;
  end
endmodule : dzc_ctrl_model

// File: verification/dzc_top_tb.sv
// Self-checking testbench of the impedance calibration block.
`timescale 1ns/100ps
module dzc_top_tb;
  import dzc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, run = 1'b0, sr = 1'b0, cke = 1'b1, odt = 1'b0;
  logic ck, busy, cur, unc, first, viol;
  logic [7:0] ron = 8'h80, rtt = 8'h80;
  dzc_cmd_t cmd = DZC_CMD_NONE;
  dzc_cmd_t c;
  dzc_link_t link;
  dzc_codes_t codes;
  dzc_codes_t ex = 16'h8080;
  int num_errors = 0, cmp_count = 0, dur, n;
  always #50 clk = !clk;
  dzc_ctrl_model dzc_ctrl_model_inst (.i_run(run), .i_cmd(cmd), .i_cke(cke), .i_odt(odt),
    .o_ck(ck), .o_link(link));
  dzc_top #(.ZQINIT_NCK(8), .ZQOPER_NCK(4), .ZQCS_NCK(2)) dzc_top_inst (.i_clk(clk),
    .i_rst(rst), .i_ck(ck), .i_link(link), .i_self_refresh(sr), .i_wl(DZC_WL_DEFAULT),
    .i_target_ron(ron), .i_target_rtt(rtt), .o_busy(busy), .o_zq_current_en(cur),
    .o_codes(codes), .o_odt_uncertain(unc), .o_first_done(first), .o_violation(viol));
  function automatic logic [7:0] step(input logic [7:0] v, input logic [7:0] t);
    return (v < t) ? v + 8'h01 : (v > t) ? v - 8'h01 : v;
  endfunction : step
  task automatic stop_test();
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task automatic check(input logic ok, input string msg);
    cmp_count++;
    if (!ok) begin
      num_errors++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic wait_busy(input logic v);
    for (n = 0; busy !== v && n < 2000; n++) @(negedge clk);
    if (n == 2000) begin
      check(1'b0, "wait timed out");
      stop_test();
    end
  endtask : wait_busy
  task automatic issue(input dzc_cmd_t k, input logic bad);
    @(posedge clk);
    cmd <= k;
    repeat (8) @(posedge clk);
    cmd <= bad ? DZC_CMD_OTHER : DZC_CMD_NONE;
    wait_busy(1'b1);
    @(posedge clk);
    cmd <= DZC_CMD_NONE;
    wait_busy(1'b0);
    dur = n;
  endtask : issue
  initial begin
    dur = $urandom(91608);
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    run <= 1'b1;
    sr <= 1'b1;
    ron <= 8'($urandom);
    repeat (100) @(negedge clk);
    check(codes === 16'h8080 && busy === 1'b0 && first === 1'b0, "idle");
    sr <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      ron <= 8'($urandom);
      rtt <= 8'($urandom);
      c = (i < 2) ? DZC_CMD_LONG : (i == 2 || $urandom % 2) ? DZC_CMD_SHORT : DZC_CMD_LONG;
      issue(c, 1'b0);
      n = (c == DZC_CMD_SHORT) ? 2 : (i == 0) ? 8 : 4;
      ex = (c == DZC_CMD_SHORT) ? {step(ex.ron, ron), step(ex.rtt, rtt)} : {ron, rtt};
      check(dur > n * 8 - 12 && dur < n * 8 + 12, "window length");
      check(codes === ex, "codes");
      check(first === 1'b1 && cur === 1'b0, "done flags");
    end
    check(viol === 1'b0 && unc === 1'b0, "false violation");
    @(posedge clk);
    cke <= 1'b0;
    for (n = 0; unc !== 1'b1 && n < 60; n++) @(negedge clk);
    check(unc === 1'b1, "uncertain window");
    @(posedge clk);
    cke <= 1'b1;
    repeat (100) @(posedge clk);
    check(unc === 1'b0, "uncertain window end");
    issue(DZC_CMD_LONG, 1'b1);
    check(viol === 1'b1, "traffic in window");
    stop_test();
  end
endmodule : dzc_top_tb
